/* hdl/tbtsc_regs.vh */
// bit positions, reset values and offsets of the 10base-t status/control block
`ifndef TBTSC_REGS_VH
`define TBTSC_REGS_VH
`define TBTSC_OFF_CTRL       4'h0
`define TBTSC_OFF_IRQ_STAT   4'h1
`define TBTSC_OFF_IRQ_MASK   4'h2
`define TBTSC_OFF_PHY_SUMMARY_STATUS     4'h3
`define TBTSC_BIT_SERIAL     15
`define TBTSC_MSB_SQ         11
`define TBTSC_LSB_SQ         9
`define TBTSC_BIT_ECHO_DIS   8
`define TBTSC_BIT_LP_INH     7
`define TBTSC_BIT_FORCE_LINK 6
`define TBTSC_BIT_POLARITY   4
`define TBTSC_BIT_RSVD_ONE   2
`define TBTSC_BIT_CT_DIS     1
`define TBTSC_BIT_LTG_DIS    0
`define TBTSC_BIT_PS_POL     12
`define TBTSC_MSB_RSVD_HI    14
`define TBTSC_LSB_RSVD_HI    12
`define TBTSC_BIT_RSVD_B5    5
`define TBTSC_BIT_RSVD_B3    3
`define TBTSC_SQ_RESET       3'h4
`define TBTSC_WR_MASK        16'h0fc7
`define TBTSC_IRQ_POL        0
`define TBTSC_IRQ_LINK       1
`define TBTSC_IRQ_W          2
`endif

/* hdl/tbtsc_sticky.v */
// latched-high flag: set wins over clear
`timescale 1ns/1ns
`default_nettype none
module tbtsc_sticky (
  input  wire clk_in,
  input  wire rst_n_in,
  input  wire ce_in,
  input  wire set_in,
  input  wire clr_in,
  output reg  flag_out
);
  // a set in the clear cycle is kept
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flag_out <= 1'b0;
    end else if (ce_in) begin
      flag_out <= set_in | (flag_out & ~clr_in);
    end
  end
endmodule // tbtsc_sticky
`default_nettype wire

/* hdl/tbtsc_strap.v */
// catches the serial mode strap one cycle after reset release
`timescale 1ns/1ns
`default_nettype none
module tbtsc_strap (
  input  wire clk_in,
  input  wire rst_n_in,
  output reg  load_out
);
  reg done_r;
  // async reset only loads constants; strap is sampled by a clocked load
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      done_r   <= 1'b0;
      load_out <= 1'b0;
    end else begin
      load_out <= ~done_r;
      done_r   <= 1'b1;
    end
  end
endmodule // tbtsc_strap
`default_nettype wire

/* hdl/tbtsc_ctrl.v */
// 10base-t status/control register with interrupt status and mask
//
// Summary of operation
// - bit 15 selects serial port mode, strapped
// - reserved bit 2 resets to one and is writable
// - bits 11:9 squelch setting, reset 100
// - half duplex 10M echoes transmit to receive
// - bit 8 suppresses echo, not basic loopback
// - bit 7 stops normal link pulses
// - bit 6 forces 10M link good
// - bit 4 latches inverted polarity, mirrors status
// - read here clears polarity; status read does not
// - bit 1 disables heartbeat in half 10M
// - heartbeat off at 100M or full duplex
// - bit 0 disables jabber in 10M only
//
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "tbtsc_regs.vh"
module tbtsc_ctrl #(
  parameter AW = 4
) (
  input  wire          clk_in,
  input  wire          rst_n_in,
  input  wire          ce_in,
  input  wire [AW-1:0] addr_in,
  input  wire [15:0]   wdata_in,
  input  wire          wr_in,
  input  wire          rd_in,
  output reg  [15:0]   rdata_out,
  output reg           irq_out,
  input  wire          serial_strap_in,
  input  wire          speed_100_in,
  input  wire          full_duplex_in,
  input  wire          pol_inverted_in,
  input  wire          link_raw_in,
  input  wire          bmc_loopback_in,
  output reg           serial_attach_mode_out,
  output reg  [2:0]    squelch_sel_out,
  output reg           tx_echo_en_out,
  output reg           bmc_loopback_out,
  output reg           link_pulse_en_out,
  output reg           link_good_out,
  output reg           heartbeat_en_out,
  output reg           jabber_en_out,
  output reg  [15:0]   phy_summary_status_out
);
  //////////////////////////////////////////////////////////////////////////
  // control register fields
  reg        serial_r;
  reg [2:0]  squelch_r;
  reg        echo_dis_r;
  reg        lp_inh_r;
  reg        force_link_r;
  reg        rsvd_one_r;
  reg        ct_dis_r;
  reg        ltg_dis_r;
  reg [15:0] rsvd_r;
  reg [`TBTSC_IRQ_W-1:0] mask_r;
  reg        link_d_r;
  wire       strap_load;
  wire       pol_flag;
  wire       ctrl_wr  = ce_in & wr_in & (addr_in == `TBTSC_OFF_CTRL);
  wire       ctrl_rd  = ce_in & rd_in & (addr_in == `TBTSC_OFF_CTRL);
  wire       stat_wr  = ce_in & wr_in & (addr_in == `TBTSC_OFF_IRQ_STAT);
  wire [`TBTSC_IRQ_W-1:0] irq_stat;
  wire [`TBTSC_IRQ_W-1:0] irq_set;
  wire [`TBTSC_IRQ_W-1:0] irq_clr;
  wire [15:0] ctrl_view;

  tbtsc_strap u_strap (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .load_out (strap_load)
  );

  // polarity latch: cleared only by a read of this register
  tbtsc_sticky u_pol (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .ce_in    (ce_in),
    .set_in   (pol_inverted_in),
    .clr_in   (ctrl_rd),
    .flag_out (pol_flag)
  );

  // interrupt events: polarity detection and link change
  assign irq_set[`TBTSC_IRQ_POL]  = pol_inverted_in & ~pol_flag;
  assign irq_set[`TBTSC_IRQ_LINK] = link_raw_in ^ link_d_r;
  assign irq_clr = stat_wr ? wdata_in[`TBTSC_IRQ_W-1:0] : {`TBTSC_IRQ_W{1'b0}};

  genvar gi;
  generate
    for (gi = 0; gi < `TBTSC_IRQ_W; gi = gi + 1) begin : g_irq
      tbtsc_sticky u_irq (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .ce_in    (ce_in),
        .set_in   (irq_set[gi]),
        .clr_in   (irq_clr[gi]),
        .flag_out (irq_stat[gi])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // register writes; reserved bits are stored but feed only the read view
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      serial_r     <= 1'b0;
      squelch_r    <= `TBTSC_SQ_RESET;
      echo_dis_r   <= 1'b0;
      lp_inh_r     <= 1'b0;
      force_link_r <= 1'b0;
      rsvd_one_r   <= 1'b1;
      ct_dis_r     <= 1'b0;
      ltg_dis_r    <= 1'b0;
      rsvd_r       <= 16'h0000;
      mask_r       <= {`TBTSC_IRQ_W{1'b0}};
      link_d_r     <= 1'b0;
    end else if (ce_in) begin
      link_d_r <= link_raw_in;
      if (strap_load) begin
        serial_r <= serial_strap_in;
      end
      if (ctrl_wr) begin
        serial_r     <= wdata_in[`TBTSC_BIT_SERIAL];
        squelch_r    <= wdata_in[`TBTSC_MSB_SQ:`TBTSC_LSB_SQ];
        echo_dis_r   <= wdata_in[`TBTSC_BIT_ECHO_DIS];
        lp_inh_r     <= wdata_in[`TBTSC_BIT_LP_INH];
        force_link_r <= wdata_in[`TBTSC_BIT_FORCE_LINK];
        rsvd_one_r   <= wdata_in[`TBTSC_BIT_RSVD_ONE];
        ct_dis_r     <= wdata_in[`TBTSC_BIT_CT_DIS];
        ltg_dis_r    <= wdata_in[`TBTSC_BIT_LTG_DIS];
        // reserved zeros kept as written so a slip is visible on read
        rsvd_r       <= wdata_in & ~`TBTSC_WR_MASK;
      end
      if (wr_in && addr_in == `TBTSC_OFF_IRQ_MASK) begin
        mask_r <= wdata_in[`TBTSC_IRQ_W-1:0];
      end
    end
  end

  // assembled view of the control register
  assign ctrl_view = {serial_r, rsvd_r[`TBTSC_MSB_RSVD_HI:`TBTSC_LSB_RSVD_HI], squelch_r,
                      echo_dis_r, lp_inh_r, force_link_r, rsvd_r[`TBTSC_BIT_RSVD_B5],
                      pol_flag, rsvd_r[`TBTSC_BIT_RSVD_B3], rsvd_one_r,
                      ct_dis_r, ltg_dis_r};

  //////////////////////////////////////////////////////////////////////////
  // read data one cycle after the strobe; unmapped reads return zero
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= 16'h0000;
    end else if (ce_in) begin
      if (rd_in) begin
        case (addr_in)
          `TBTSC_OFF_CTRL:     rdata_out <= ctrl_view;
          `TBTSC_OFF_IRQ_STAT: rdata_out <= {{(16-`TBTSC_IRQ_W){1'b0}}, irq_stat};
          `TBTSC_OFF_IRQ_MASK: rdata_out <= {{(16-`TBTSC_IRQ_W){1'b0}}, mask_r};
          // status copy read does not clear the latch
          `TBTSC_OFF_PHY_SUMMARY_STATUS:   rdata_out <= phy_summary_status_out;
          default:             rdata_out <= 16'h0000;
        endcase
      end else begin
        rdata_out <= 16'h0000;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // datapath controls, all registered
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      serial_attach_mode_out <= 1'b0;
      squelch_sel_out        <= `TBTSC_SQ_RESET;
      tx_echo_en_out         <= 1'b0;
      bmc_loopback_out       <= 1'b0;
      link_pulse_en_out      <= 1'b0;
      link_good_out          <= 1'b0;
      heartbeat_en_out       <= 1'b0;
      jabber_en_out          <= 1'b0;
      phy_summary_status_out <= 16'h0000;
      irq_out                <= 1'b0;
    end else if (ce_in) begin
      // serial mode ignored at 100M
      serial_attach_mode_out <= serial_r & ~speed_100_in;
      squelch_sel_out        <= squelch_r;
      tx_echo_en_out <= ~speed_100_in & ~full_duplex_in & ~echo_dis_r;
      // basic loopback passes untouched by the echo disable
      bmc_loopback_out       <= bmc_loopback_in;
      link_pulse_en_out      <= ~speed_100_in & ~lp_inh_r;
      link_good_out <= speed_100_in ? link_raw_in : (force_link_r | link_raw_in);
      heartbeat_en_out <= ~speed_100_in & ~full_duplex_in & ~ct_dis_r;
      jabber_en_out          <= ~speed_100_in & ~ltg_dis_r;
      phy_summary_status_out <= {15'h0000, pol_flag} << `TBTSC_BIT_PS_POL;
      irq_out                <= |(irq_stat & mask_r);
    end
  end
endmodule // tbtsc_ctrl
`default_nettype wire

/* verification/tbtsc_ctrl_props.sv */
// port-level assertions for the 10base-t status/control register
`timescale 1ns/1ns
`default_nettype none
module tbtsc_ctrl_props #(parameter AW = 4) (
  input wire logic          clk_in,
  input wire logic          rst_n_in,
  input wire logic          ce_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic          rd_in,
  input wire logic          speed_100_in,
  input wire logic          full_duplex_in,
  input wire logic          pol_inverted_in,
  input wire logic          link_raw_in,
  input wire logic          bmc_loopback_in,
  input wire logic [15:0]   rdata_out,
  input wire logic          tx_echo_en_out,
  input wire logic          link_good_out,
  input wire logic          heartbeat_en_out,
  input wire logic          jabber_en_out,
  input wire logic          bmc_loopback_out,
  input wire logic [15:0]   phy_summary_status_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  ////////////////////////////////////////////////////////////////
  // heartbeat and echo muted at 100M or full duplex, jabber at 100M
  a_hb_fast_off: assert property ($past(ce_in && (speed_100_in || full_duplex_in))
    |-> !heartbeat_en_out) else $error("heartbeat on outside half 10M");
  a_echo_fast_off: assert property ($past(ce_in && (speed_100_in || full_duplex_in))
    |-> !tx_echo_en_out) else $error("echo on outside half 10M");
  a_jab_fast_off: assert property ($past(ce_in && speed_100_in)
    |-> !jabber_en_out) else $error("jabber on at 100M");
  // guarded by reset so the first edge after release is not judged
  a_link_raw_good: assert property ($past(ce_in && rst_n_in && link_raw_in)
    |-> link_good_out) else $error("raw link lost");
  a_loop_pass: assert property ($past(ce_in && rst_n_in)
    |-> bmc_loopback_out == $past(bmc_loopback_in)) else $error("loopback altered");
  a_read_idle_zero: assert property ($past(ce_in && !rd_in)
    |-> rdata_out == 16'h0000) else $error("read data outside slot");
  // read of control clears the latch at its edge; the status copy drops one edge later, unless set again
  a_pol_read_clr: assert property ((rd_in && ce_in && addr_in == '0 && !pol_inverted_in)
    ##1 (ce_in && !pol_inverted_in) |=> !phy_summary_status_out[12])
    else $error("polarity not cleared");
  a_pol_latch: assert property ((ce_in && pol_inverted_in) [*2]
    |=> phy_summary_status_out[12]) else $error("polarity not latched");
endmodule // tbtsc_ctrl_props
bind tbtsc_ctrl tbtsc_ctrl_props #(.AW(AW)) u_props (.*);
`default_nettype wire

/* verification/tenbase_t_status_control_reg_tb.sv */
// self-checking bench for the 10base-t status/control register
`timescale 1ns/1ns
`default_nettype none
module tenbase_t_status_control_reg_tb;
  logic        clk_in = 0, rst_n_in = 0, ce_in = 1, wr_in = 0, rd_in = 0;
  logic [3:0]  addr_in = '0;
  logic [15:0] wdata_in = '0;
  logic        serial_strap_in = 1, speed_100_in = 0, full_duplex_in = 0;
  logic        pol_inverted_in = 0, link_raw_in = 0, bmc_loopback_in = 0;
  wire  [15:0] rdata_out, phy_summary_status_out;
  wire  [2:0]  squelch_sel_out;
  wire         irq_out, serial_attach_mode_out, tx_echo_en_out, bmc_loopback_out;
  wire         link_pulse_en_out, link_good_out, heartbeat_en_out, jabber_en_out;
  int          n_mismatch = 0, check_count = 0;
  // control word, {speed, duplex}, {serial, echo, pulse, link, heartbeat, jabber}
  logic [23:0] rows [6] = '{{16'h0804, 2'b00, 6'b011011}, {16'h89c7, 2'b00, 6'b100100},
    {16'h89c7, 2'b10, 6'b000000}, {16'h0404, 2'b01, 6'b001001},
    {16'h0804, 2'b10, 6'b000000}, {16'h0e44, 2'b00, 6'b011111}};
  tbtsc_ctrl u_tbtsc_ctrl (.*);
  ////////////////////////////////////////////////////////////////
  // clock and shared tasks
  always #5 clk_in = ~clk_in;
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_in);
    wr_in <= 1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 0;
  endtask
  // read data stand only in the slot after the strobe
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_in);
    rd_in <= 1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 0;
    #1 chk(rdata_out, e);
  endtask
  task automatic wrap_up;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // hang guard
  initial begin
    #100000;
    n_mismatch++;
    wrap_up;
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    cyc(12);
    rst_n_in <= 1;
    cyc(2);
    rd(4'h0, 16'h8804);
    chk({13'h0, squelch_sel_out}, 16'h0004);
    chk({15'h0, serial_attach_mode_out}, 16'h0001);
    // table of control words against speed and duplex
    for (int i = 0; i < 6; i++) begin
      {speed_100_in, full_duplex_in} <= rows[i][7:6];
      wr(4'h0, rows[i][23:8]);
      cyc(2);
      chk({10'h0, serial_attach_mode_out, tx_echo_en_out, link_pulse_en_out, link_good_out,
        heartbeat_en_out, jabber_en_out}, {10'h0, rows[i][5:0]});
      chk({13'h0, squelch_sel_out}, {13'h0, rows[i][19:17]});
      rd(4'h0, rows[i][23:8]);
    end
    // polarity event through the unmasked interrupt; settle link first
    wr(4'h0, 16'h0804);
    cyc(3);
    wr(4'h1, 16'h0003);
    wr(4'h2, 16'h0001);
    pol_inverted_in <= 1;
    cyc(2);
    pol_inverted_in <= 0;
    cyc(3);
    chk({15'h0, irq_out}, 16'h0001);
    rd(4'h1, 16'h0001);
    rd(4'h3, 16'h1000);
    rd(4'h3, 16'h1000);
    rd(4'h0, 16'h0814);
    rd(4'h0, 16'h0804);
    rd(4'h3, 16'h0000);
    wr(4'h1, 16'h0001);
    cyc(2);
    chk({15'h0, irq_out}, 16'h0000);
    // masked link change stays quiet until unmasked
    link_raw_in <= 1;
    bmc_loopback_in <= 1;
    cyc(3);
    chk({15'h0, irq_out}, 16'h0000);
    chk({14'h0, link_good_out, bmc_loopback_out}, 16'h0003);
    rd(4'h1, 16'h0002);
    wr(4'h2, 16'h0002);
    cyc(2);
    chk({15'h0, irq_out}, 16'h0001);
    wr(4'h1, 16'h0002);
    cyc(2);
    chk({15'h0, irq_out}, 16'h0000);
    rd(4'hf, 16'h0000);
    // clock enable low freezes the register against a write
    ce_in <= 0;
    wr(4'h0, 16'h0e44);
    ce_in <= 1;
    rd(4'h0, 16'h0804);
    // mid-run reset restores defaults and reloads the strap
    wr(4'h0, 16'h0e44);
    rst_n_in <= 0;
    cyc(2);
    rst_n_in <= 1;
    cyc(2);
    rd(4'h0, 16'h8804);
    chk({13'h0, squelch_sel_out}, 16'h0004);
    wrap_up;
  end
endmodule // tenbase_t_status_control_reg_tb
`default_nettype wire
